// >>> rtl/ebr_master.sv
// External bus read master: S0..S5 sequence with acknowledge-driven wait states.
// Assumes all bus inputs are asynchronous pins; the write cycle is not handled here.
`timescale 1ns/1ps
module ebr_master (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  // Request side
  input  wire logic                        i_req,
  input  wire logic [ebr_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ebr_pkg::FC_W-1:0]    i_fc,
  input  wire logic [1:0]                  i_size,
  input  wire logic                        i_async_mode,
  input  wire logic                        i_fast_term,
  output logic                             o_busy,
  output logic                             o_done,
  output logic [ebr_pkg::DATA_W-1:0]       o_rdata,
  output logic [1:0]                       o_port_width,
  // Bus pins
  input  wire logic [ebr_pkg::DATA_W-1:0]  i_data,
  input  wire logic                        i_port_ack_hi_n,
  input  wire logic                        i_port_ack_lo_n,
  output logic                             o_bus_clk,
  output logic [ebr_pkg::ADDR_W-1:0]       o_addr,
  output logic [ebr_pkg::FC_W-1:0]         o_function_code,
  output logic                             o_xfer_size_hi,
  output logic                             o_xfer_size_lo,
  output logic                             o_rw,
  output logic                             o_addr_strobe_n,
  output logic                             o_data_strobe_n,
  output logic                             o_out_en_n,
  output logic [ebr_pkg::LANES-1:0]        o_lane_en
);
  import ebr_pkg::*;

  typedef struct packed {
    ebr_state_t        st;
    logic              ph;
    logic [1:0]        await;
    logic              fast;
    logic              async_m;
    logic [ADDR_W-1:0] addr;
    logic [FC_W-1:0]   fc;
    logic [1:0]        size;
    logic              rw;
    logic              as_n;
    logic              ds_n;
    logic              oe_n;
    logic [1:0]        ack_s1;
    logic [1:0]        ack_s2;
    logic [DATA_W-1:0] d_s1;
    logic [DATA_W-1:0] d_s2;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        pw;
    logic              done;
  } ebr_regs_t;

  ebr_regs_t s;
  ebr_regs_t next_s;
  logic      ack_seen;
  logic      strobing;

  // Only the second synchronizer stage is ever looked at
  assign ack_seen = (s.ack_s2 != ACK_NONE);

  always_comb
  begin
    next_s        = s;
    next_s.ph     = ~s.ph;
    next_s.done   = 1'b0;
    next_s.ack_s1 = {i_port_ack_hi_n, i_port_ack_lo_n}; // RULE3
    next_s.ack_s2 = s.ack_s1;                           // RULE7
    next_s.d_s1   = i_data;                             // RULE3
    next_s.d_s2   = s.d_s1;                             // RULE7
    unique case (s.st)
      ST_IDLE, ST_S5:
      begin
        if (s.st == ST_S5)
        begin
          next_s.done = 1'b1;
          next_s.st   = ST_IDLE;
        end
        // A cycle may only open on a rising bus clock edge
        if (!s.ph && i_req)
        begin
          next_s.st      = ST_S0;
          next_s.addr    = i_addr;        // RULE20
          next_s.fc      = i_fc;          // RULE20
          next_s.size    = i_size;        // RULE20
          next_s.rw      = 1'b1;          // RULE20
          next_s.fast    = i_fast_term;
          next_s.async_m = i_async_mode;
          next_s.await   = i_async_mode ? ASYNC_WAIT_PAIRS : 2'h0; // RULE3
        end
      end
      ST_S0:
        next_s.st = ST_S1;
      ST_S1:
        next_s.st = s.fast ? ST_S4 : ST_S2; // RULE5
      ST_S2, ST_WHI:
      begin
        // Decision taken at the falling edge that ends this high phase
        if (ack_seen && s.await == 2'h0) // RULE6 RULE11 RULE2 RULE4
          next_s.st = ST_S3;
        else
        begin
          next_s.st = ST_WLO; // RULE12
          if (s.await != 2'h0)
            next_s.await = 2'(s.await - 2'h1);
        end
      end
      ST_WLO:
        next_s.st = ST_WHI;
      ST_S3:
        next_s.st = ST_S4;
      ST_S4:
      begin
        next_s.st    = ST_S5;
        next_s.rdata = s.d_s2; // RULE14 RULE11
        if (s.fast)
          next_s.pw = FAST_PW;
        else
        begin
          unique case (s.ack_s2) // RULE19 RULE1
            ACK_32:  next_s.pw = PW_32;
            ACK_16:  next_s.pw = PW_16;
            ACK_8:   next_s.pw = PW_8;
            default: next_s.pw = PW_NONE;
          endcase
        end
      end
      default:
        next_s.st = ST_IDLE;
    endcase
    // Strobes live from S1 through S4 and all wait states
    strobing = next_s.st inside {ST_S1, ST_S2, ST_S3, ST_S4, ST_WLO, ST_WHI}; // RULE8
    next_s.as_n = ~strobing; // RULE15
    next_s.ds_n = ~strobing;
    next_s.oe_n = ~strobing;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s        <= '0;
      s.as_n   <= 1'b1;
      s.ds_n   <= 1'b1;
      s.oe_n   <= 1'b1;
      s.ack_s1 <= ACK_NONE;
      s.ack_s2 <= ACK_NONE;
    end
    else
      s <= next_s;
  end

  // Byte lane i = 3 carries D31..D24, i.e. address offset 0
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      localparam logic [2:0] OFS = 3'(LANES - 1 - gi);
      assign o_lane_en[gi] = (OFS >= {1'b0, s.addr[1:0]}) &&
                             (OFS < 3'({1'b0, s.addr[1:0]} + size_bytes(s.size))); // RULE9
    end
  endgenerate

  assign o_bus_clk       = s.ph;
  assign o_busy          = (s.st != ST_IDLE);
  assign o_done          = s.done;
  assign o_rdata         = s.rdata;
  assign o_port_width    = s.pw;
  assign o_addr          = s.addr;  // RULE15
  assign o_function_code = s.fc;    // RULE16
  assign o_xfer_size_hi  = s.size[1];
  assign o_xfer_size_lo  = s.size[0];
  assign o_rw            = s.rw;
  assign o_addr_strobe_n = s.as_n;
  assign o_data_strobe_n = s.ds_n;
  assign o_out_en_n      = s.oe_n;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  s0_quiet_a: assert property ((s.st == ST_S0) |-> (s.as_n && s.ds_n && s.oe_n)) // RULE20
    else $error("strobe active in S0");
  s1_strobes_a: assert property ((s.st == ST_S0) |=>
      (s.st == ST_S1 && !s.as_n && !s.ds_n && !s.oe_n)) // RULE8
    else $error("strobes not asserted in S1");
  s5_release_a: assert property ((s.st == ST_S5) |->
      (s.as_n && s.ds_n && s.oe_n && s.addr == $past(s.addr))) // RULE15
    else $error("S5 strobes or address wrong");
  s5_attrs_a: assert property ((s.st == ST_S5) |-> $stable({s.rw, s.size, s.fc})) // RULE16
    else $error("attributes changed in S5");
  wait_insert_a: assert property ((s.st inside {ST_S2, ST_WHI} && !ack_seen) |=>
      (s.st == ST_WLO) ##1 (s.st == ST_WHI)) // RULE12
    else $error("missing wait state");
  ack_path_a: assert property ((s.st == ST_S2 && ack_seen && s.await == 2'h0) |=>
      (s.st == ST_S3) ##1 (s.st == ST_S4) ##1 (s.st == ST_S5) ##1 o_done) // RULE11
    else $error("acknowledged cycle did not finish");
  three_clk_a: assert property ((s.st == ST_S0 && !s.async_m && !s.fast) ##2
      (s.st == ST_S2 && ack_seen) |-> ##4 o_done) // RULE4
    else $error("synchronous cycle not three clocks");
  fast_term_a: assert property ((s.st == ST_S0 && s.fast) |-> ##4 o_done) // RULE5
    else $error("fast cycle not two clocks");
  latch_fall_a: assert property ((s.rdata != $past(s.rdata)) |->
      ($past(s.st) == ST_S4 && $past(s.ph))) // RULE6
    else $error("data latched off the falling edge");
  data_latch_a: assert property ((s.st == ST_S4) |=> (s.rdata == $past(s.d_s2))) // RULE14
    else $error("S4 data not latched");
  sync_depth_a: assert property (s.ack_s2 == $past({i_port_ack_hi_n, i_port_ack_lo_n}, 2)) // RULE3
    else $error("acknowledge synchronizer depth wrong");
  width_16_a: assert property ((s.st == ST_S4 && !s.fast && s.ack_s2 == ACK_16) |=>
      (s.pw == PW_16)) // RULE19
    else $error("16-bit width not reported");
  lane_long_a: assert property ((s.size == SIZE_LONG && s.addr[1:0] == 2'h0) |->
      (o_lane_en == 4'hF)) // RULE9
    else $error("long-word lanes wrong");

  cov_fast_c: cover property ((s.st == ST_S1 && s.fast) ##1 (s.st == ST_S4));
  cov_wait_c: cover property ((s.st == ST_WHI) ##1 (s.st == ST_S3));
  cov_byte_c: cover property ((s.st == ST_S4 && s.ack_s2 == ACK_8) ##2 o_done);
  cov_b2b_c:  cover property ((s.st == ST_S5) ##1 (s.st == ST_S0));

endmodule // ebr_master

// >>> rtl/ebr_pkg.sv
// Constants, encodings and helpers for the external bus read master.
// Assumes one 100 MHz core clock; the bus clock is derived from it by halving.
// Operation
// RULE1: Ports of 8, 16 or 32 bits
// RULE2: Addressed device decides cycle length
// RULE3: Asynchronous inputs pass a synchronizer first
// RULE4: Synchronous mode finishes in three clocks
// RULE5: Fast termination finishes in two clocks
// RULE6: Inputs captured at falling bus clock edge
// RULE7: Captured inputs resolve to firm levels
// RULE8: S1 asserts address, data strobes, output enable
// RULE9: Size and low address pick byte lanes
// RULE10: Device drives data and acknowledge together
// RULE11: Acknowledge at S2 end, latch at S4
// RULE12: No acknowledge means wait states, keep sampling
// RULE13: Device holds acknowledges negated to wait
// RULE14: S4 end latches data and port width
// RULE15: S5 drops strobes, address stays valid
// RULE16: Direction, size, function code valid through S5
// RULE17: Device holds data until strobe negation
// RULE18: Device releases within one clock after; the model in prompt mode never releases
// RULE19: Acknowledge pair encodes port width
// RULE20: S0 drives address, code, size, direction
package ebr_pkg;

  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 32;
  localparam int FC_W          = 4;
  localparam int LANES         = 4;
  localparam int CLK_PERIOD_NS = 10;

  // Bus states; each but ST_IDLE lasts one core clock, i.e. half a bus clock
  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_WLO, ST_WHI
  } ebr_state_t;

  // Transfer size codes {xfer_size_hi, xfer_size_lo}
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // Acknowledge pair {port_ack_hi_n, port_ack_lo_n}
  localparam logic [1:0] ACK_32   = 2'h0;
  localparam logic [1:0] ACK_16   = 2'h1;
  localparam logic [1:0] ACK_8    = 2'h2;
  localparam logic [1:0] ACK_NONE = 2'h3;

  // Port width report
  localparam logic [1:0] PW_NONE = 2'h0;
  localparam logic [1:0] PW_8    = 2'h1;
  localparam logic [1:0] PW_16   = 2'h2;
  localparam logic [1:0] PW_32   = 2'h3;

  // Extra wait pairs that cover synchronizer delay in asynchronous mode
  localparam logic [1:0] ASYNC_WAIT_PAIRS = 2'h1;
  // Width reported by a fast-terminated chip-select cycle
  localparam logic [1:0] FAST_PW = PW_32;

  // Bytes moved by one transfer of the given size
  function automatic logic [2:0] size_bytes(input logic [1:0] size);
    unique case (size)
      SIZE_BYTE:  size_bytes = 3'h1;
      SIZE_WORD:  size_bytes = 3'h2;
      SIZE_THREE: size_bytes = 3'h3;
      default:    size_bytes = 3'h4;
    endcase
  endfunction

endpackage

// >>> verif/ebr_dev_model.sv
// Behavioural external memory that answers read cycles of the bus master.
// Assumes the testbench sets the word, width code, delay and prompt mode.
`timescale 1ns/1ps
module ebr_dev_model (
  // Clock and bus pins
  input  wire logic        i_clk,
  input  wire logic        i_data_strobe_n,
  output logic [31:0]      o_data,
  output logic             o_port_ack_hi_n,
  output logic             o_port_ack_lo_n,
  // Test control
  input  wire logic [31:0] i_word,
  input  wire logic [1:0]  i_ack,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_prompt
);
  logic [3:0] wait_cnt = 4'h0;
  logic       drive;
  // Device decides cycle length by holding the acknowledges off
  always_ff @(posedge i_clk)
    if (i_data_strobe_n)
      wait_cnt <= 4'h0;
    else if (wait_cnt != 4'hF)
      wait_cnt <= wait_cnt + 4'h1;
  // Prompt mode answers early, as a synchronous port would
  assign drive = i_prompt || (!i_data_strobe_n && wait_cnt >= i_delay);
  // Released: acknowledges pulled up, data shows the inverse so stale values never pass
  assign {o_port_ack_hi_n, o_port_ack_lo_n} = drive ? i_ack : 2'h3;
  assign o_data = drive ? i_word : ~i_word;
endmodule // ebr_dev_model

// >>> verif/tb_top.sv
// Self-checking bench for the external bus read master and its device model.
// Assumes the model answers every cycle; expectations are noted per request.
`timescale 1ns/1ps
module tb_top;
  import ebr_pkg::*;
  typedef struct {
    logic [31:0] data;
    logic [31:0] addr;
    logic [3:0]  lanes;
    logic [3:0]  fc;
    logic [1:0]  pw;
    logic [1:0]  size;
    int          lat;
    bit          exact;
  } ebr_note_t;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_req = 1'b0;
  logic        i_async_mode = 1'b0;
  logic        i_fast_term = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic [3:0]  i_fc = 4'h0;
  logic [1:0]  i_size = 2'h0;
  logic [31:0] i_data, o_rdata, o_addr, m_word = 32'h0, fall_addr, hold_addr;
  logic        i_port_ack_hi_n, i_port_ack_lo_n, o_busy, o_done, o_bus_clk, o_rw;
  logic        o_xfer_size_hi, o_xfer_size_lo, o_addr_strobe_n, o_data_strobe_n, o_out_en_n;
  logic [3:0]  o_function_code, o_lane_en, fall_lanes, m_delay = 4'h0;
  logic [1:0]  o_port_width, m_ack = 2'h3;
  logic [6:0]  hold_attr;
  logic        m_prompt = 1'b0;
  logic        prev_as = 1'b1;
  int          errors = 0;
  int          tests_run = 0;
  int          cnt = 0;
  ebr_note_t   q[$];

  always #5 i_clk = ~i_clk;

  ebr_master ebr_master_i (.i_clk, .i_resetn, .i_req, .i_addr, .i_fc, .i_size, .i_async_mode,
    .i_fast_term, .o_busy, .o_done, .o_rdata, .o_port_width, .i_data, .i_port_ack_hi_n,
    .i_port_ack_lo_n, .o_bus_clk, .o_addr, .o_function_code, .o_xfer_size_hi,
    .o_xfer_size_lo, .o_rw, .o_addr_strobe_n, .o_data_strobe_n, .o_out_en_n, .o_lane_en);

  ebr_dev_model ebr_dev_model_i (.i_clk, .i_data_strobe_n(o_data_strobe_n), .o_data(i_data),
    .o_port_ack_hi_n(i_port_ack_hi_n), .o_port_ack_lo_n(i_port_ack_lo_n), .i_word(m_word),
    .i_ack(m_ack), .i_delay(m_delay), .i_prompt(m_prompt));

  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(inout int k);
    @(posedge i_clk);
    #1;
    k++;
    if (k > 300)
    begin
      errors++;
      give_verdict();
    end
  endtask

  function automatic logic [3:0] lanes_of(input logic [1:0] off, input logic [1:0] sz);
    int n = (sz == 2'h0) ? 4 : int'(sz);
    for (int b = 0; b < 4; b++)
      lanes_of[3 - b] = (b >= off) && (b < off + n);
  endfunction

  function automatic logic [1:0] pw_of(input logic [1:0] ak);
    return (ak == ACK_32) ? PW_32 : (ak == ACK_16) ? PW_16 : PW_8;
  endfunction

  task automatic run(input logic f, input logic a, input logic p, input logic [3:0] d,
                     input logic [1:0] ak, input int lat, input bit ex, input int reps);
    int k;
    k = 0;
    m_word = $urandom;
    m_ack = ak;
    m_delay = d;
    m_prompt = p;
    step(k);
    step(k);
    for (int r = 0; r < reps; r++)
    begin
      i_addr = $urandom;
      i_size = 2'($urandom);
      i_fc = 4'($urandom);
      i_fast_term = f;
      i_async_mode = a;
      i_req = 1'b1;
      q.push_back('{m_word, i_addr, lanes_of(i_addr[1:0], i_size), i_fc,
                    f ? FAST_PW : pw_of(ak), i_size, lat, ex});
      while (o_addr_strobe_n !== 1'b1) step(k);
      while (o_addr_strobe_n !== 1'b0) step(k);
    end
    i_req = 1'b0;
    while (o_busy !== 1'b0 || q.size() != 0) step(k);
  endtask

  // Watches the pins mid-cycle, where outputs are settled, and retires the oldest note
  always @(negedge i_clk)
  begin
    ebr_note_t n;
    cnt = cnt + 1;
    if (prev_as && o_addr_strobe_n === 1'b0)
    begin
      cnt = 0;
      fall_lanes = o_lane_en;
      fall_addr = o_addr;
      cmp({o_data_strobe_n, o_out_en_n}, 2'h0);
      cmp({o_bus_clk, o_busy}, 2'h1);
    end
    if (!prev_as && o_addr_strobe_n === 1'b1)
    begin
      hold_addr = o_addr;
      hold_attr = {o_function_code, o_xfer_size_hi, o_xfer_size_lo, o_rw};
      cmp({o_data_strobe_n, o_out_en_n}, 2'h3);
      cmp({o_bus_clk, o_busy}, 2'h1);
    end
    prev_as = o_addr_strobe_n;
    if (o_done === 1'b1)
    begin
      if (q.size() == 0)
        cmp(1, 0);
      else
      begin
        n = q.pop_front();
        cmp(o_rdata, n.data);
        cmp(o_port_width, n.pw);
        cmp(fall_lanes, n.lanes);
        cmp(fall_addr, n.addr);
        cmp(hold_addr, n.addr);
        cmp(hold_attr, {n.fc, n.size, 1'b1});
        cmp(n.exact ? (cnt == n.lat) : (cnt >= n.lat), 1);
      end
    end
  end

  initial
  begin
    logic [1:0] codes [3];
    int         s;
    codes = '{ACK_32, ACK_16, ACK_8};
    s = $urandom(49);
    repeat (12) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    foreach (codes[c]) run(0, 0, 1, 4'h0, codes[c], 5, 1, 1);
    run(1, 0, 1, 4'h0, ACK_8, 3, 1, 1);
    run(0, 0, 0, 4'h4, ACK_32, 7, 0, 1);
    run(0, 1, 1, 4'h0, ACK_16, 7, 0, 1);
    run(0, 0, 1, 4'h0, ACK_32, 5, 1, 2);
    for (int r = 0; r < 8; r++)
      run(0, 0, 0, 4'($urandom_range(1, 6)), codes[$urandom_range(0, 2)], 7, 0, 1);
    give_verdict();
  end
endmodule // tb_top
